// File: ccio_pkg.sv
// constants, port codes and carrier types for the comm controller i/o logic
// assumes a single 10 MHz clock domain; all link inputs are sampled, tx data is a registered output
package ccio_pkg;
  localparam logic [2:0] OP_LINK = 3'h0;
  localparam logic [2:0] OP_HOST_STAT = 3'h1;
  localparam logic [2:0] OP_HOST_DATA = 3'h2;
  localparam logic [2:0] OP_RX_DATA = 3'h3;
  localparam logic [2:0] OP_ASYNC = 3'h4;
  localparam logic [2:0] OP_WR_LINK_CTL = 3'h0;
  localparam logic [2:0] OP_WR_HOST = 3'h1;
  localparam logic [2:0] OP_WR_FILL = 3'h2;
  localparam logic [2:0] OP_WR_TX = 3'h3;
  localparam logic [2:0] OP_WR_SYNC = 3'h5;
  localparam int CB_CLR_KEY = 7;
  localparam int CB_SYNC = 6;
  localparam int CB_CLR_TICK = 5;
  localparam int CB_LAST = 4;
  localparam int CB_CLR_ERR = 3;
  localparam int LC_TX_IE = 2;
  localparam int LC_RX_IE = 3;
  localparam int CLK_HZ = 10000000;
  localparam int TICK_MS = 8;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] VEC_IRQ = 16'h0010;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] FILL_RST = 8'hff;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } ccio_host_byte_t;

  typedef struct packed {
    logic tick;
    logic dsr;
    logic dcd;
    logic cts;
    logic overrun;
    logic rx_rdy;
    logic tx_rdy;
    logic underrun;
  } ccio_link_stat_t;
endpackage : ccio_pkg

// File: ccio_top.sv
// comm controller i/o glue: processor port, host strobes, sync rx and tx
// assumes processor port signals are on clk_i; pins and modem clocks are async
// ========================================
// two-flop synchroniser
// ========================================
module ccio_sync (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1_q <= d_i;
      q_o <= s1_q;
    end
  end
endmodule : ccio_sync

// ========================================
// fifo toward the host
// ========================================
module ccio_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q, rp_q;
  wire do_wr = in_valid_i && in_ready_o;
  wire do_rd = out_valid_o && out_ready_i;
  assign in_ready_o = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign out_valid_o = wp_q != rp_q;
  assign out_data_o = mem_q[rp_q[AW-1:0]];
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (do_wr) wp_q <= wp_q + 1'b1;
      if (do_rd) rp_q <= rp_q + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (do_wr) mem_q[wp_q[AW-1:0]] <= in_data_i;
  end
endmodule : ccio_fifo

// ========================================
// top
// ========================================
module ccio_top #(
  parameter int TICK_CYCLES = ccio_pkg::TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // processor i/o port, one-cycle strobes
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_operand_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic irq_o,
  input wire logic cpu_inte_i,
  output logic cpu_trap_o,
  output logic [15:0] cpu_vector_o,
  output logic cpu_reset_o,
  // host side
  input wire logic [7:0] host_data_i,
  input wire logic command_strobe_i,
  input wire logic output_byte_strobe_i,
  input wire logic host_ready_i,
  input wire logic host_select_i,
  input wire logic host_reset_key_i,
  output logic device_ready_o,
  output logic [7:0] host_out_data_o,
  output logic host_input_strobe_o,
  output logic last_byte_flag_o,
  output logic host_fifo_ready_o,
  // modem side
  input wire logic rx_data_i,
  input wire logic rx_sup_data_i,
  input wire logic rx_clk_i,
  input wire logic tx_clk_i,
  input wire logic cts_i,
  input wire logic dcd_i,
  input wire logic dsr_i,
  output logic tx_data_o
);
  initial begin
    if (TICK_CYCLES < 2) $error("tick period too short");
  end

  // ========================================
  // reset and input synchronisers
  // ========================================
  logic rs1_q, rs2_q, mrst_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  wire rst_n = rs2_q;
  // master reset, after the command strobe that asked for it
  wire mrst_n = rst_n && !mrst_q;

  localparam int NS = 11;
  logic [NS-1:0] raw_w, syn_w;
  assign raw_w = {command_strobe_i, output_byte_strobe_i, host_ready_i, host_select_i,
                  host_reset_key_i, rx_data_i, rx_sup_data_i, rx_clk_i, tx_clk_i,
                  cts_i, dcd_i};
  for (genvar g = 0; g < NS; g++) begin : g_sync
    ccio_sync u_s (.clk_i(clk_i), .rstn_i(rst_n), .d_i(raw_w[g]), .q_o(syn_w[g]));
  end
  logic dsr_s;
  ccio_sync u_dsr (.clk_i(clk_i), .rstn_i(rst_n), .d_i(dsr_i), .q_o(dsr_s));
  wire cbs_s = syn_w[10];
  wire obs_s = syn_w[9];
  wire hrdy_s = syn_w[8];
  wire hsel_s = syn_w[7];
  wire key_s = syn_w[6];
  wire rxd_s = syn_w[5];
  wire rxsup_s = syn_w[4];
  wire rxc_s = syn_w[3];
  wire txc_s = syn_w[2];
  wire cts_s = syn_w[1];
  wire dcd_s = syn_w[0];

  logic cbs_p_q, obs_p_q, key_p_q, rxc_p_q, txc_p_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cbs_p_q <= 1'b0;
      obs_p_q <= 1'b0;
      key_p_q <= 1'b0;
      rxc_p_q <= 1'b0;
      txc_p_q <= 1'b0;
    end else begin
      cbs_p_q <= cbs_s;
      obs_p_q <= obs_s;
      key_p_q <= key_s;
      rxc_p_q <= rxc_s;
      txc_p_q <= txc_s;
    end
  end
  wire cbs_ev = cbs_s && !cbs_p_q;
  wire obs_ev = obs_s && !obs_p_q;
  wire key_ev = key_s && !key_p_q;
  wire rx_fall = rxc_p_q && !rxc_s;
  wire tx_rise = txc_s && !txc_p_q;

  // ========================================
  // operand decode
  // ========================================
  wire io_any = io_rd_i || io_wr_i;
  wire [2:0] opc = io_operand_i[2:0];
  wire clr_key = io_any && io_operand_i[ccio_pkg::CB_CLR_KEY];
  wire start_sync = io_any && io_operand_i[ccio_pkg::CB_SYNC];
  wire clr_tick = io_any && io_operand_i[ccio_pkg::CB_CLR_TICK];
  wire clr_err = io_any && io_operand_i[ccio_pkg::CB_CLR_ERR];
  wire rd_hdata = io_rd_i && opc == ccio_pkg::OP_HOST_DATA;
  wire rd_rx = io_rd_i && opc == ccio_pkg::OP_RX_DATA;
  wire wr_lctl = io_wr_i && opc == ccio_pkg::OP_WR_LINK_CTL;
  wire wr_host = io_wr_i && opc == ccio_pkg::OP_WR_HOST;
  wire wr_fill = io_wr_i && opc == ccio_pkg::OP_WR_FILL;
  wire wr_tx = io_wr_i && opc == ccio_pkg::OP_WR_TX;
  wire wr_sync = io_wr_i && opc == ccio_pkg::OP_WR_SYNC;

  // ========================================
  // host interface state
  // ========================================
  logic [7:0] hdata_q;
  logic obs_seen_q, cbs_seen_q, key_q, dev_rdy_q;
  wire host_ev = cbs_ev || obs_ev;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hdata_q <= ccio_pkg::RST_BYTE;
      obs_seen_q <= 1'b0;
      cbs_seen_q <= 1'b0;
      key_q <= 1'b0;
      dev_rdy_q <= 1'b1;
      mrst_q <= 1'b0;
    end else begin
      if (host_ev) hdata_q <= host_data_i;
      obs_seen_q <= obs_ev || (obs_seen_q && !rd_hdata);
      cbs_seen_q <= cbs_ev || (cbs_seen_q && !rd_hdata);
      dev_rdy_q <= host_ev ? 1'b0 : (rd_hdata ? 1'b1 : dev_rdy_q);
      key_q <= key_ev || (key_q && !clr_key);
      mrst_q <= cbs_ev && host_data_i[7];
    end
  end
  wire hrdy_live = hrdy_s && hsel_s;

  // ========================================
  // link control, tick timer
  // ========================================
  logic tx_ie_q, rx_ie_q, tick_q;
  logic [31:0] tcnt_q;
  wire tick_ev = tcnt_q == 32'(TICK_CYCLES - 1);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_ie_q <= 1'b0;
      rx_ie_q <= 1'b0;
      tick_q <= 1'b0;
      tcnt_q <= '0;
    end else if (!mrst_n) begin
      tx_ie_q <= 1'b0;
      rx_ie_q <= 1'b0;
      tick_q <= 1'b0;
      tcnt_q <= '0;
    end else begin
      if (wr_lctl) begin
        tx_ie_q <= io_wdata_i[ccio_pkg::LC_TX_IE];
        rx_ie_q <= io_wdata_i[ccio_pkg::LC_RX_IE];
      end
      tcnt_q <= tick_ev ? '0 : tcnt_q + 1'b1;
      tick_q <= tick_ev || (tick_q && !clr_tick);
    end
  end

  // ========================================
  // receiver
  // ========================================
  logic [7:0] rsh_q, rbuf_q, smatch_q;
  logic [2:0] rcnt_q;
  logic insync_q, rx_rdy_q, ovr_q;
  wire [7:0] rsh_n = {rxd_s, rsh_q[7:1]};
  wire hunt_hit = rx_fall && !insync_q && rsh_n == smatch_q;
  wire rx_done = rx_fall && insync_q && rcnt_q == 3'h7;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsh_q <= ccio_pkg::RST_BYTE;
      rbuf_q <= ccio_pkg::RST_BYTE;
      smatch_q <= ccio_pkg::RST_BYTE;
      rcnt_q <= '0;
      insync_q <= 1'b0;
      rx_rdy_q <= 1'b0;
      ovr_q <= 1'b0;
    end else if (!mrst_n) begin
      rcnt_q <= '0;
      insync_q <= 1'b0;
      rx_rdy_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      if (wr_sync) smatch_q <= io_wdata_i;
      if (rx_fall) rsh_q <= rsh_n;
      if (start_sync) begin
        insync_q <= 1'b0;
      end else if (hunt_hit) begin
        insync_q <= 1'b1;
        rcnt_q <= '0;
      end else if (rx_fall && insync_q) begin
        rcnt_q <= rcnt_q + 1'b1;
      end
      if (rx_done) rbuf_q <= rsh_n;
      rx_rdy_q <= rx_done || (rx_rdy_q && !rd_rx);
      ovr_q <= (rx_done && rx_rdy_q && !rd_rx) || (ovr_q && !clr_err);
    end
  end

  // ========================================
  // transmitter
  // ========================================
  logic [7:0] tbuf_q, fill_q, tsh_q;
  logic [2:0] tcnt8_q;
  logic tbuf_full_q, tx_rdy_q, und_q, txd_q;
  wire tx_reload = tx_rise && tcnt8_q == 3'h7;
  wire tx_take = tx_reload && tbuf_full_q;
  wire tx_fill = tx_reload && !tbuf_full_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tbuf_q <= ccio_pkg::RST_BYTE;
      fill_q <= ccio_pkg::FILL_RST;
      tsh_q <= ccio_pkg::FILL_RST;
      tcnt8_q <= '0;
      tbuf_full_q <= 1'b0;
      tx_rdy_q <= 1'b1;
      und_q <= 1'b0;
      txd_q <= 1'b1;
    end else if (!mrst_n) begin
      tcnt8_q <= '0;
      tbuf_full_q <= 1'b0;
      tx_rdy_q <= 1'b1;
      und_q <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      if (wr_fill) fill_q <= io_wdata_i;
      if (wr_tx) tbuf_q <= io_wdata_i;
      tbuf_full_q <= wr_tx || (tbuf_full_q && !tx_take);
      tx_rdy_q <= wr_tx ? 1'b0 : (tx_take ? 1'b1 : tx_rdy_q);
      if (tx_rise) begin
        tcnt8_q <= tcnt8_q + 1'b1;
        txd_q <= cts_s ? tsh_q[0] : 1'b1;
        tsh_q <= tx_take ? tbuf_q : (tx_fill ? fill_q : {1'b1, tsh_q[7:1]});
      end else if (!cts_s) begin
        txd_q <= 1'b1;
      end
      und_q <= tx_fill || (und_q && !clr_err);
    end
  end

  // ========================================
  // bytes toward the host
  // ========================================
  ccio_pkg::ccio_host_byte_t hin_w, hout_w;
  logic hout_valid, hin_ready, strobe_q;
  assign hin_w = '{data: io_wdata_i, last: io_operand_i[ccio_pkg::CB_LAST]};
  ccio_fifo #(.WIDTH(9), .DEPTH(8)) u_fifo (
    .clk_i(clk_i),
    .rst_ni(mrst_n),
    .in_valid_i(wr_host),
    .in_ready_o(hin_ready),
    .in_data_i(hin_w),
    .out_valid_o(hout_valid),
    .out_ready_i(hrdy_live && !strobe_q),
    .out_data_o(hout_w)
  );
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strobe_q <= 1'b0;
      host_out_data_o <= ccio_pkg::RST_BYTE;
      last_byte_flag_o <= 1'b0;
      host_fifo_ready_o <= 1'b0;
    end else begin
      strobe_q <= hout_valid && hrdy_live && !strobe_q;
      if (hout_valid && hrdy_live && !strobe_q) begin
        host_out_data_o <= hout_w.data;
        last_byte_flag_o <= hout_w.last;
      end
      host_fifo_ready_o <= hin_ready;
    end
  end
  assign host_input_strobe_o = strobe_q;

  // ========================================
  // read mux and processor outputs
  // ========================================
  ccio_pkg::ccio_link_stat_t lstat_w;
  assign lstat_w = '{tick: tick_q, dsr: dsr_s, dcd: dcd_s, cts: cts_s, overrun: ovr_q,
                     rx_rdy: rx_rdy_q, tx_rdy: tx_rdy_q, underrun: und_q};
  wire [7:0] hstat_w = {4'h0, hrdy_live, key_q, cbs_seen_q, obs_seen_q};
  // parity and framing only exist in async mode, read as zero here
  wire [7:0] astat_w = {4'h0, rxsup_s, rxd_s, 1'b0, 1'b0};
  wire [7:0] rsel_w = (opc == ccio_pkg::OP_LINK) ? lstat_w :
                      (opc == ccio_pkg::OP_HOST_STAT) ? hstat_w :
                      (opc == ccio_pkg::OP_HOST_DATA) ? hdata_q :
                      (opc == ccio_pkg::OP_RX_DATA) ? rbuf_q :
                      (opc == ccio_pkg::OP_ASYNC) ? astat_w : 8'h00;
  wire irq_w = (rx_rdy_q && rx_ie_q) || (tx_rdy_q && tx_ie_q);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      io_rdata_o <= ccio_pkg::RST_BYTE;
      irq_o <= 1'b0;
      cpu_trap_o <= 1'b0;
      cpu_vector_o <= ccio_pkg::VEC_RESET;
      cpu_reset_o <= 1'b0;
      device_ready_o <= 1'b1;
      tx_data_o <= 1'b1;
    end else begin
      if (io_rd_i) io_rdata_o <= rsel_w;
      irq_o <= irq_w;
      cpu_trap_o <= irq_w && cpu_inte_i;
      cpu_vector_o <= mrst_q ? ccio_pkg::VEC_RESET : ccio_pkg::VEC_IRQ;
      cpu_reset_o <= mrst_q;
      device_ready_o <= dev_rdy_q;
      tx_data_o <= txd_q;
    end
  end
endmodule : ccio_top

// File: ccio_checker.sv
// concurrent checks on the comm controller i/o top ports
// assumes one clk_i domain; bound to ccio_top below
module ccio_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_operand_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic cpu_reset_o,
  input wire logic [15:0] cpu_vector_o,
  input wire logic host_input_strobe_o,
  input wire logic host_ready_i,
  input wire logic [7:0] host_out_data_o,
  input wire logic last_byte_flag_o,
  input wire logic device_ready_o,
  input wire logic cts_i,
  input wire logic tx_clk_i,
  input wire logic tx_data_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic [3:0] quiet_q;
  // ========================================
  // cycles since the tx clock or cts last moved
  // ========================================
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) quiet_q <= 4'h0;
    else if ($changed(tx_clk_i) || $changed(cts_i)) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  // ========================================
  // properties
  // ========================================
  sequence s_host_rd;
    io_rd_i && io_operand_i[2:0] == 3'h2;
  endsequence
  property p_vec;
    $past(rstn_i) |-> cpu_vector_o == (cpu_reset_o ? 16'h0000 : 16'h0010);
  endproperty
  property p_rst_pulse;
    cpu_reset_o |=> !cpu_reset_o;
  endproperty
  property p_stb_pulse;
    host_input_strobe_o |=> !host_input_strobe_o;
  endproperty
  property p_stb_ready;
    host_input_strobe_o |-> $past(host_ready_i, 2) || $past(host_ready_i, 3)
      || $past(host_ready_i, 4) || $past(host_ready_i, 5);
  endproperty
  property p_rd_ready;
    s_host_rd |-> ##2 device_ready_o;
  endproperty
  property p_ready_cause;
    $rose(device_ready_o) |-> $past(io_rd_i && io_operand_i[2:0] == 3'h2, 2);
  endproperty
  property p_tx_hold;
    !cts_i [*5] |-> tx_data_o;
  endproperty
  property p_tx_quiet;
    quiet_q >= 4'h6 |-> $stable(tx_data_o);
  endproperty
  property p_rdata_stands;
    !$past(io_rd_i) |-> $stable(io_rdata_o);
  endproperty
  property p_data_hold;
    $changed({host_out_data_o, last_byte_flag_o}) |-> host_input_strobe_o;
  endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset too long");
  a_stb_pulse: assert property (p_stb_pulse) else $error("strobe too long");
  a_stb_ready: assert property (p_stb_ready) else $error("strobe w/o ready");
  a_rd_ready: assert property (p_rd_ready) else $error("ready not raised");
  a_ready_cause: assert property (p_ready_cause) else $error("ready rose");
  a_tx_hold: assert property (p_tx_hold) else $error("tx not held");
  a_tx_quiet: assert property (p_tx_quiet) else $error("tx moved");
  a_rdata_stands: assert property (p_rdata_stands) else $error("rdata moved");
  a_data_hold: assert property (p_data_hold) else $error("host data moved");
endmodule : ccio_checker

bind ccio_top ccio_checker u_ccio_checker (.clk_i, .rstn_i, .io_rd_i, .io_operand_i,
  .io_rdata_o, .cpu_reset_o, .cpu_vector_o, .host_input_strobe_o, .host_ready_i,
  .host_out_data_o, .last_byte_flag_o, .device_ready_o, .cts_i, .tx_clk_i, .tx_data_o);

// File: ccio_far_model.sv
// far side model: host strobes and a synchronous modem
// assumes the bench calls its tasks; modem clocks stand still between frames
module ccio_far_model (
  input wire logic device_ready_i,
  input wire logic tx_data_i,
  output logic [7:0] host_data_o,
  output logic command_strobe_o,
  output logic output_byte_strobe_o,
  output logic rx_data_o,
  output logic rx_clk_o,
  output logic tx_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] tx_bits;
  initial begin
    host_data_o = 8'h00;
    command_strobe_o = 1'b0;
    output_byte_strobe_o = 1'b0;
    rx_data_o = 1'b1;
    rx_clk_o = 1'b1;
    tx_clk_o = 1'b0;
  end
  // ========================================
  // host byte, sent once ready is seen or after 200 polls of 100 ns
  // ========================================
  task automatic host_byte(input logic [7:0] d, input logic cmd);
    int n;
    n = 0;
    while (device_ready_i !== 1'b1 && n < 200) begin
      #100;
      n++;
    end
    host_data_o = d;
    #200;
    if (cmd) command_strobe_o = 1'b1;
    else output_byte_strobe_o = 1'b1;
    #300;
    command_strobe_o = 1'b0;
    output_byte_strobe_o = 1'b0;
    #500;
    host_data_o = ~d;
  endtask : host_byte
  // ========================================
  // serial frames, lsb first
  // ========================================
  task automatic rx_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      rx_data_o = d[i];
      #400;
      rx_clk_o = 1'b0;
      #400;
      rx_clk_o = 1'b1;
    end
    rx_data_o = ~d[7];
  endtask : rx_byte
  task automatic tx_edges(input int n);
    repeat (n) begin
      tx_clk_o = 1'b1;
      #500;
      tx_bits = {tx_data_i, tx_bits[31:1]};
      tx_clk_o = 1'b0;
      #300;
    end
  endtask : tx_edges
endmodule : ccio_far_model

// File: tb_top.sv
// self-checking bench for ccio_top with far side model
// assumes 10 MHz clock and a shortened tick period
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICKS = 50;
  logic clk_i, rstn_i, io_rd_i, io_wr_i, cpu_inte_i, host_ready_i, host_select_i;
  logic host_reset_key_i, rx_sup_data_i, cts_i, dcd_i, dsr_i, irq_o, cpu_trap_o;
  logic cpu_reset_o, command_strobe_i, output_byte_strobe_i, device_ready_o;
  logic host_input_strobe_o, last_byte_flag_o, host_fifo_ready_o, rx_data_i;
  logic rx_clk_i, tx_clk_i, tx_data_o, rd_q, found;
  logic [7:0] io_operand_i, io_wdata_i, io_rdata_o, host_data_i, host_out_data_o;
  logic [15:0] cpu_vector_o;
  int failures, checked, seed, cyc, nstb;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  ccio_pkg::ccio_host_byte_t host_q[$];
  ccio_top #(.TICK_CYCLES(TICKS)) u_ccio_top (.clk_i, .rstn_i, .io_rd_i, .io_wr_i,
    .io_operand_i, .io_wdata_i, .io_rdata_o, .irq_o, .cpu_inte_i, .cpu_trap_o,
    .cpu_vector_o, .cpu_reset_o, .host_data_i, .command_strobe_i, .output_byte_strobe_i,
    .host_ready_i, .host_select_i, .host_reset_key_i, .device_ready_o, .host_out_data_o,
    .host_input_strobe_o, .last_byte_flag_o, .host_fifo_ready_o, .rx_data_i,
    .rx_sup_data_i, .rx_clk_i, .tx_clk_i, .cts_i, .dcd_i, .dsr_i, .tx_data_o);
  ccio_far_model u_ccio_far_model (.device_ready_i(device_ready_o), .tx_data_i(tx_data_o),
    .host_data_o(host_data_i), .command_strobe_o(command_strobe_i),
    .output_byte_strobe_o(output_byte_strobe_i), .rx_data_o(rx_data_i),
    .rx_clk_o(rx_clk_i), .tx_clk_o(tx_clk_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ========================================
  // helpers
  // ========================================
  task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic close_out;
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic io(input logic rd, input logic [7:0] op, input logic [7:0] wd,
                    input logic [7:0] ex, input logic [7:0] mk);
    tick(1);
    io_rd_i = rd;
    io_wr_i = ~rd;
    io_operand_i = op;
    io_wdata_i = wd;
    if (rd) begin
      exp_q.push_back(ex & mk);
      msk_q.push_back(mk);
    end
    tick(1);
    io_rd_i = 1'b0;
    io_wr_i = 1'b0;
  endtask : io
  // ========================================
  // watchers and timeout
  // ========================================
  always @(posedge clk_i) rd_q <= io_rd_i;
  always @(negedge clk_i) begin
    if (rd_q === 1'b1 && exp_q.size() > 0) begin
      check("rdata", {1'b0, io_rdata_o & msk_q.pop_front()}, {1'b0, exp_q.pop_front()});
    end
    if (host_input_strobe_o === 1'b1) begin
      nstb++;
      if (host_q.size() > 0) check("host byte", {host_out_data_o, last_byte_flag_o}, host_q.pop_front());
      else check("extra strobe", 9'h001, 9'h000);
    end
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  // ========================================
  // main sequence
  // ========================================
  initial begin
    int n;
    logic [7:0] d;
    seed = 9;
    {failures, checked, cyc, nstb} = '0;
    {rstn_i, io_rd_i, io_wr_i, host_ready_i, host_reset_key_i, cts_i, dsr_i} = '0;
    {cpu_inte_i, host_select_i, rx_sup_data_i, dcd_i} = 4'hf;
    io_operand_i = 8'h00;
    io_wdata_i = 8'h00;
    tick(16);
    rstn_i = 1'b1;
    tick(4);
    io(1, 8'h00, 8'h00, 8'h22, 8'h7f);
    io(1, 8'h04, 8'h00, 8'h0c, 8'h0f);
    io(0, 8'h00, 8'h04, 8'h00, 8'h00);
    tick(3);
    check("irq", {8'h00, irq_o}, 9'h001);
    check("trap", {8'h00, cpu_trap_o}, 9'h001);
    cpu_inte_i = 1'b0;
    tick(3);
    check("trap", {8'h00, cpu_trap_o}, 9'h000);
    cpu_inte_i = 1'b1;
    io(0, 8'h00, 8'h00, 8'h00, 8'h00);
    tick(3);
    check("irq", {8'h00, irq_o}, 9'h000);
    tick(TICKS + 10);
    io(1, 8'h00, 8'h00, 8'h80, 8'h80);
    io(1, 8'h20, 8'h00, 8'h00, 8'h00);
    io(1, 8'h00, 8'h00, 8'h00, 8'h80);
    host_ready_i = 1'b1;
    d = 8'($random(seed));
    u_ccio_far_model.host_byte(d, 1'b0);
    tick(8);
    io(1, 8'h01, 8'h00, 8'h09, 8'h0f);
    check("dev ready", {8'h00, device_ready_o}, 9'h000);
    io(1, 8'h02, 8'h00, d, 8'hff);
    tick(2);
    check("dev ready", {8'h00, device_ready_o}, 9'h001);
    io(1, 8'h01, 8'h00, 8'h08, 8'h0f);
    u_ccio_far_model.host_byte(8'h55, 1'b1);
    host_select_i = 1'b0;
    tick(8);
    io(1, 8'h01, 8'h00, 8'h02, 8'h0f);
    host_select_i = 1'b1;
    io(1, 8'h02, 8'h00, 8'h55, 8'hff);
    host_reset_key_i = 1'b1;
    tick(5);
    host_reset_key_i = 1'b0;
    tick(4);
    io(1, 8'h01, 8'h00, 8'h0c, 8'h0f);
    io(1, 8'h81, 8'h00, 8'h00, 8'h00);
    io(1, 8'h01, 8'h00, 8'h08, 8'h0f);
    d = 8'($random(seed));
    io(0, 8'h02, 8'hf0, 8'h00, 8'h00);
    io(0, 8'h03, d, 8'h00, 8'h00);
    io(1, 8'h00, 8'h00, 8'h00, 8'h02);
    cts_i = 1'b1;
    tick(4);
    u_ccio_far_model.tx_edges(10);
    io(1, 8'h00, 8'h00, 8'h02, 8'h03);
    u_ccio_far_model.tx_edges(16);
    io(1, 8'h00, 8'h00, 8'h01, 8'h01);
    found = 1'b0;
    for (n = 0; n <= 16; n++) found |= (u_ccio_far_model.tx_bits[n+:16] === {8'hf0, d});
    check("tx stream", {8'h00, found}, 9'h001);
    cts_i = 1'b0;
    tick(8);
    check("tx idle", {8'h00, tx_data_o}, 9'h001);
    io(1, 8'h08, 8'h00, 8'h00, 8'h00);
    io(1, 8'h00, 8'h00, 8'h00, 8'h01);
    io(0, 8'h05, 8'h96, 8'h00, 8'h00);
    io(1, 8'h40, 8'h00, 8'h00, 8'h00);
    d = 8'($random(seed));
    u_ccio_far_model.rx_byte(8'h96);
    u_ccio_far_model.rx_byte(d ^ 8'h5a);
    u_ccio_far_model.rx_byte(d);
    tick(6);
    io(0, 8'h00, 8'h08, 8'h00, 8'h00);
    tick(3);
    check("irq", {8'h00, irq_o}, 9'h001);
    io(1, 8'h00, 8'h00, 8'h0c, 8'h0c);
    io(1, 8'h03, 8'h00, d, 8'hff);
    io(1, 8'h00, 8'h00, 8'h08, 8'h0c);
    tick(3);
    check("irq", {8'h00, irq_o}, 9'h000);
    io(1, 8'h08, 8'h00, 8'h00, 8'h00);
    io(1, 8'h00, 8'h00, 8'h00, 8'h08);
    host_ready_i = 1'b0;
    tick(4);
    for (n = 0; n < 9; n++) begin
      d = 8'($random(seed));
      if (n < 8) host_q.push_back('{data: d, last: (n == 7)});
      io(0, (n == 7) ? 8'h11 : 8'h01, d, 8'h00, 8'h00);
    end
    tick(2);
    check("fifo ready", {8'h00, host_fifo_ready_o}, 9'h000);
    check("strobes", 9'(nstb), 9'h000);
    for (n = 0; n < 400 && nstb < 8; n++) begin
      host_ready_i = 1'($random(seed));
      tick(3);
    end
    host_ready_i = 1'b1;
    tick(10);
    check("strobes", 9'(nstb), 9'h008);
    d = 8'h80 | d;
    // reset pulse lasts one cycle, so watch it while the strobe is still running
    fork
      u_ccio_far_model.host_byte(d, 1'b1);
      begin
        for (n = 0; n < 40 && cpu_reset_o !== 1'b1; n++) @(negedge clk_i);
        check("cpu reset", {8'h00, cpu_reset_o}, 9'h001);
      end
    join
    tick(4);
    io(1, 8'h02, 8'h00, d, 8'hff);
    tick(4);
    close_out();
  end
endmodule : tb_top
